// file: cdt_pkg.sv
package cdt_pkg;

  // ---------------------------------------------------------------
  // register numbers and selects
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_TAG_LOW   = 5'h1C;
  localparam logic [4:0] REG_TAG_HIGH  = 5'h1D;
  localparam logic [2:0] SEL_ICACHE_TAG  = 3'h0;
  localparam logic [2:0] SEL_ICACHE_DATA = 3'h1;
  localparam logic [2:0] SEL_DCACHE_TAG  = 3'h2;
  localparam logic [2:0] SEL_DCACHE_DATA = 3'h3;

  // ---------------------------------------------------------------
  // low tag field layout
  // ---------------------------------------------------------------
  localparam int PTAG_MSB  = 31;
  localparam int PTAG_LSB  = 8;
  localparam int STATE_MSB = 7;
  localparam int STATE_LSB = 6;
  localparam int LOCK_BIT  = 5;
  localparam int IMPL_MSB  = 4;
  localparam int IMPL_LSB  = 3;
  localparam int RSVD_MSB  = 2;
  localparam int RSVD_LSB  = 1;
  localparam int PAR_BIT   = 0;

  // bits of the low tag that are stored; reserved bits 2:1 always zero
  localparam logic [31:0] TAG_LOW_MASK = 32'hFFFF_FFF9;

  // extended physical tag: upper word holds tag address bits beyond 31
  localparam int XTAG_W = 32;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int IDX_W   = 6;
  localparam int DEPTH   = 64;
  localparam int WORD_W  = 32;

  typedef enum logic [1:0] {
    CDT_OP_NONE     = 2'b00,
    CDT_OP_LOAD_TAG = 2'b01,
    CDT_OP_STORE_TAG = 2'b10
  } cdt_op_t;

  typedef struct packed {
    logic [31:0] xtag;
    logic [31:0] tag_low;
    logic [31:0] tag_high;
    logic [31:0] data_low;
    logic [31:0] data_high;
  } cdt_line_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [4:0]  regnum;
    logic [2:0]  sel;
    logic        xword;
    logic [31:0] wdata;
  } cdt_reg_req_t;

  typedef struct packed {
    logic        valid;
    cdt_op_t     op;
    logic        dcache;
    logic [IDX_W-1:0] index;
  } cdt_cache_req_t;

endpackage

// file: cdt_array.sv
`timescale 1ns/1ns
`default_nettype none

module cdt_array
  import cdt_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             wr_i,
  input  wire logic [IDX_W-1:0] addr_i,
  input  wire cdt_line_t        wline_i,
  output cdt_line_t             rline_o
);

  // ---------------------------------------------------------------
  // one cache's tag and data entries
  // ---------------------------------------------------------------
  cdt_line_t mem [DEPTH];
  cdt_line_t rline_ff;

  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wline_i;
    end
    rline_ff <= mem[addr_i];
  end

  assign rline_o = rline_ff;

endmodule

`default_nettype wire

// file: cdt_diag_regs.sv
`timescale 1ns/1ns
`default_nettype none

module cdt_diag_regs
  import cdt_pkg::*;
#(
  parameter int XTAG_IMPL = 4
)
(
  input  wire logic           clk_i,
  input  wire logic           srst_i,
  input  wire cdt_reg_req_t   reg_req_i,
  output logic                reg_ack_o,
  output logic                reg_hit_o,
  output logic [31:0]         reg_rdata_o,
  input  wire cdt_cache_req_t cache_req_i,
  output logic                cache_busy_o,
  output logic                cache_done_o
);

  // ---------------------------------------------------------------
  // register storage, one set per cache
  // ---------------------------------------------------------------
  cdt_line_t regs_ff [2];
  cdt_line_t nxt_regs [2];
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        ack_ff;
  logic        nxt_ack;
  logic        hit_ff;
  logic        nxt_hit;

  // ---------------------------------------------------------------
  // cache operation sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CDT_IDLE  = 2'b00,
    CDT_READ  = 2'b01,
    CDT_FILL  = 2'b10
  } cdt_state_t;

  cdt_state_t       state_ff;
  cdt_state_t       nxt_state;
  logic             dsel_ff;
  logic             nxt_dsel;
  logic [IDX_W-1:0] idx_ff;
  logic [IDX_W-1:0] nxt_idx;
  logic             done_ff;
  logic             nxt_done;

  logic [31:0] xtag_mask;
  logic        arr_wr [2];
  cdt_line_t   arr_rd [2];

  // tag store writes the selected cache's register set into the array
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cache
      assign arr_wr[g] = cache_req_i.valid && (state_ff == CDT_IDLE)
                         && (cache_req_i.op == CDT_OP_STORE_TAG)
                         && (cache_req_i.dcache == 1'(g));
      cdt_array u_array (
        .clk_i   (clk_i),
        .wr_i    (arr_wr[g]),
        .addr_i  ((state_ff == CDT_IDLE) ? cache_req_i.index : idx_ff),
        .wline_i (regs_ff[g]),
        .rline_o (arr_rd[g])
      );
    end
  endgenerate

  assign xtag_mask = (32'h1 << XTAG_IMPL) - 32'h1;

  function automatic logic [31:0] read_sel(cdt_line_t r, logic [4:0] rn, logic [2:0] s);
    logic [31:0] v;
    v = 32'h0;
    if (rn == REG_TAG_LOW) begin
      if (s == SEL_ICACHE_TAG || s == SEL_DCACHE_TAG) begin
        v = r.tag_low & TAG_LOW_MASK;
      end else begin
        v = r.data_low;
      end
    end else begin
      if (s == SEL_ICACHE_TAG || s == SEL_DCACHE_TAG) begin
        v = r.tag_high;
      end else begin
        v = r.data_high;
      end
    end
    return v;
  endfunction

  always_comb begin
    logic       sel_ok;
    logic       cidx;
    cdt_line_t  cur;
    sel_ok = 1'b0;
    cidx   = 1'b0;
    cur    = regs_ff[0];
    nxt_regs[0] = regs_ff[0];
    nxt_regs[1] = regs_ff[1];
    nxt_rdata = rdata_ff;
    nxt_ack   = 1'b0;
    nxt_hit   = 1'b0;
    nxt_state = state_ff;
    nxt_dsel  = dsel_ff;
    nxt_idx   = idx_ff;
    nxt_done  = 1'b0;

    // register access: even select tag, odd select data, bit 1 picks cache
    sel_ok = (reg_req_i.regnum == REG_TAG_LOW || reg_req_i.regnum == REG_TAG_HIGH)
             && (reg_req_i.sel[2] == 1'b0);
    cidx   = reg_req_i.sel[1];
    cur    = regs_ff[cidx];
    if (reg_req_i.valid) begin
      nxt_ack = 1'b1;
      nxt_hit = sel_ok;
      if (!sel_ok) begin
        nxt_rdata = 32'h0;
      end else if (reg_req_i.write) begin
        if (reg_req_i.regnum == REG_TAG_LOW && !reg_req_i.sel[0]) begin
          if (reg_req_i.xword) begin
            cur.xtag = reg_req_i.wdata & xtag_mask;
          end else begin
            cur.tag_low = reg_req_i.wdata & TAG_LOW_MASK;
          end
        end else if (reg_req_i.regnum == REG_TAG_LOW) begin
          cur.data_low = reg_req_i.wdata;
        end else if (!reg_req_i.sel[0]) begin
          cur.tag_high = reg_req_i.wdata;
        end else begin
          cur.data_high = reg_req_i.wdata;
        end
        nxt_regs[cidx] = cur;
      end else if (reg_req_i.xword && reg_req_i.regnum == REG_TAG_LOW
                   && !reg_req_i.sel[0]) begin
        nxt_rdata = cur.xtag & xtag_mask;
      end else begin
        nxt_rdata = read_sel(cur, reg_req_i.regnum, reg_req_i.sel);
      end
    end

    case (state_ff)
      CDT_IDLE: begin
        if (cache_req_i.valid) begin
          nxt_dsel = cache_req_i.dcache;
          nxt_idx  = cache_req_i.index;
          if (cache_req_i.op == CDT_OP_LOAD_TAG) begin
            nxt_state = CDT_READ;
          end else begin
            nxt_done = 1'b1;
          end
        end
      end
      CDT_READ: begin
        nxt_state = CDT_FILL;
      end
      CDT_FILL: begin
        // load overrides a same-cycle register write to that set
        nxt_regs[dsel_ff] = arr_rd[dsel_ff];
        nxt_regs[dsel_ff].tag_low = arr_rd[dsel_ff].tag_low & TAG_LOW_MASK;
        nxt_regs[dsel_ff].xtag = arr_rd[dsel_ff].xtag & xtag_mask;
        nxt_done  = 1'b1;
        nxt_state = CDT_IDLE;
      end
      default: begin
        nxt_state = CDT_IDLE;
      end
    endcase
  end

  // register contents, captured index and cache select are not reset; state, ack, hit, done and read data reset
  always_ff @(posedge clk_i) begin
    regs_ff[0] <= nxt_regs[0];
    regs_ff[1] <= nxt_regs[1];
    idx_ff     <= nxt_idx;
    dsel_ff    <= nxt_dsel;
    if (srst_i) begin
      state_ff <= CDT_IDLE;
      rdata_ff <= 32'h0;
      ack_ff   <= 1'b0;
      hit_ff   <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
      ack_ff   <= nxt_ack;
      hit_ff   <= nxt_hit;
      done_ff  <= nxt_done;
    end
  end

  assign reg_ack_o    = ack_ff;
  assign reg_hit_o    = hit_ff;
  assign reg_rdata_o  = rdata_ff;
  assign cache_done_o = done_ff;
  assign cache_busy_o = (state_ff != CDT_IDLE);

endmodule

`default_nettype wire

// file: cdt_diag_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cdt_diag_regs_checker
  import cdt_pkg::*;
#(
  parameter int XTAG_IMPL = 4
)
(
  input wire logic           clk_i,
  input wire logic           srst_i,
  input wire cdt_reg_req_t   reg_req_i,
  input wire logic           reg_ack_o,
  input wire logic           reg_hit_o,
  input wire logic [31:0]    reg_rdata_o,
  input wire cdt_cache_req_t cache_req_i,
  input wire logic           cache_busy_o,
  input wire logic           cache_done_o
);
  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  logic hit_c, lt_rd, xt_rd, st_go, ld_go;
  assign hit_c = (reg_req_i.regnum == REG_TAG_LOW || reg_req_i.regnum == REG_TAG_HIGH)
                 && !reg_req_i.sel[2];
  assign lt_rd = reg_req_i.valid && !reg_req_i.write && reg_req_i.regnum == REG_TAG_LOW
                 && reg_req_i.sel[2:0] inside {3'h0, 3'h2};
  assign xt_rd = lt_rd && reg_req_i.xword;
  assign st_go = cache_req_i.valid && !cache_busy_o && cache_req_i.op == CDT_OP_STORE_TAG;
  assign ld_go = cache_req_i.valid && !cache_busy_o && cache_req_i.op == CDT_OP_LOAD_TAG;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_ld_fill; cache_busy_o [*2]; endsequence
  sequence s_ld_end; cache_done_o && !cache_busy_o; endsequence
  AST_ACK: assert property (reg_req_i.valid |=> reg_ack_o)
    else $error("request not acknowledged");
  AST_ACK_SRC: assert property (reg_ack_o |-> $past(reg_req_i.valid))
    else $error("acknowledge without request");
  AST_HIT: assert property (reg_ack_o |-> reg_hit_o == $past(hit_c))
    else $error("hit decode wrong");
  AST_UNMAP: assert property (reg_ack_o && !reg_hit_o && !$past(reg_req_i.write)
    |-> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RSVD: assert property (reg_ack_o && $past(lt_rd && !reg_req_i.xword)
    |-> reg_rdata_o[2:1] == 2'h0)
    else $error("reserved tag bits not zero");
  AST_XTAG: assert property (reg_ack_o && $past(xt_rd)
    |-> (reg_rdata_o >> XTAG_IMPL) == 32'h0)
    else $error("unimplemented tag bits not zero");
  AST_STORE: assert property (st_go |=> s_ld_end)
    else $error("store timing wrong");
  AST_LOAD: assert property (ld_go |=> s_ld_fill ##1 s_ld_end)
    else $error("load timing wrong");
  AST_BUSY: assert property ($rose(cache_busy_o) |-> $past(ld_go))
    else $error("busy without load");
endmodule
bind cdt_diag_regs cdt_diag_regs_checker #(.XTAG_IMPL(XTAG_IMPL)) u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .reg_req_i(reg_req_i), .reg_ack_o(reg_ack_o),
  .reg_hit_o(reg_hit_o), .reg_rdata_o(reg_rdata_o), .cache_req_i(cache_req_i),
  .cache_busy_o(cache_busy_o), .cache_done_o(cache_done_o));
`default_nettype wire

// file: cdt_pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
module cdt_pipe_model
  import cdt_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             go_i,
  input  wire cdt_op_t          op_i,
  input  wire logic             dc_i,
  input  wire logic [IDX_W-1:0] idx_i,
  input  wire logic             busy_i,
  output cdt_cache_req_t        req_o
);
  // ---------------------------------------------------------------
  // cache operation issue, held until taken
  // ---------------------------------------------------------------
  cdt_cache_req_t nxt_req;
  always_comb begin
    nxt_req = req_o;
    if (go_i) begin
      nxt_req = '{1'h1, op_i, dc_i, idx_i};
    end else if (!busy_i) begin
      // released fields change every cycle
      nxt_req = cdt_cache_req_t'({1'h0, ~req_o[8:0]});
    end
  end
  always_ff @(posedge clk_i) begin
    req_o <= srst_i ? cdt_cache_req_t'(10'h0) : nxt_req;
  end
endmodule
`default_nettype wire

// file: tb_cdt_diag_regs.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cdt_diag_regs
  import cdt_pkg::*;
;
  typedef struct packed {
    logic [4:0]  rn;
    logic [2:0]  sl;
    logic        xw;
    logic [31:0] d;
    logic [31:0] e;
    logic        h;
  } cdt_row_t;
  logic clk_i, srst_i, go, dc, ack, hit, busy, done;
  logic [31:0] rdata;
  logic [IDX_W-1:0] idx;
  cdt_op_t op;
  cdt_reg_req_t rq;
  cdt_cache_req_t creq;
  int n_mismatch, checked;
  cdt_row_t tbl [11];
  cdt_diag_regs dut (.clk_i(clk_i), .srst_i(srst_i), .reg_req_i(rq), .reg_ack_o(ack),
    .reg_hit_o(hit), .reg_rdata_o(rdata), .cache_req_i(creq), .cache_busy_o(busy),
    .cache_done_o(done));
  cdt_pipe_model u_pipe (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .op_i(op), .dc_i(dc),
    .idx_i(idx), .busy_i(busy), .req_o(creq));
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  task results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] a, input logic [31:0] e);
    checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task acc(input logic w, input logic [4:0] rn, input logic [2:0] sl, input logic xw,
           input logic [31:0] d, input logic [31:0] e, input logic h);
    @(posedge clk_i);
    #1 rq = '{1'h1, w, rn, sl, xw, d};
    @(posedge clk_i);
    #1 rq = cdt_reg_req_t'({1'h0, ~rq[41:0]});
    chk({31'h0, ack}, 32'h1);
    chk({31'h0, hit}, {31'h0, h});
    if (!w) chk(rdata, e);
  endtask
  task cop(input cdt_op_t o, input logic c, input logic [IDX_W-1:0] x);
    int i;
    @(posedge clk_i);
    #1 go = 1'h1;
    op = o;
    dc = c;
    idx = x;
    @(posedge clk_i);
    #1 go = 1'h0;
    for (i = 0; i < 20 && done !== 1'h1; i++) @(posedge clk_i) #1;
    if (i == 20) begin
      n_mismatch++;
      results();
    end
    chk(i, (o == CDT_OP_LOAD_TAG) ? 32'h3 : 32'h1);
    chk({31'h0, busy}, 32'h0);
  endtask
  initial begin
    n_mismatch = 0;
    checked = 0;
    rq = cdt_reg_req_t'(43'h0);
    go = 1'h0;
    dc = 1'h0;
    idx = '0;
    op = CDT_OP_NONE;
    srst_i = 1'h1;
    tbl = '{'{5'h1C, 3'h0, 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFF9, 1'h1},
            '{5'h1C, 3'h2, 1'h0, 32'h1234_567E, 32'h1234_5678, 1'h1},
            '{5'h1C, 3'h0, 1'h1, 32'hFFFF_FFFF, 32'h0000_000F, 1'h1},
            '{5'h1D, 3'h0, 1'h0, 32'h0, 32'h0, 1'h1},
            '{5'h1D, 3'h2, 1'h0, 32'hA5A5_A5A5, 32'hA5A5_A5A5, 1'h1},
            '{5'h1C, 3'h1, 1'h0, 32'h1111_1111, 32'h1111_1111, 1'h1},
            '{5'h1C, 3'h3, 1'h0, 32'h2222_2222, 32'h2222_2222, 1'h1},
            '{5'h1D, 3'h1, 1'h0, 32'h3333_3333, 32'h3333_3333, 1'h1},
            '{5'h1D, 3'h3, 1'h0, 32'h4444_4444, 32'h4444_4444, 1'h1},
            '{5'h1E, 3'h0, 1'h0, 32'h5A5A_5A5A, 32'h0, 1'h0},
            '{5'h1C, 3'h5, 1'h0, 32'h5A5A_5A5A, 32'h0, 1'h0}};
    repeat (3) @(posedge clk_i);
    #1 srst_i = 1'h0;
    chk({31'h0, ack}, 32'h0);
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 11; i++)
        acc(p == 0, tbl[i].rn, tbl[i].sl, tbl[i].xw, tbl[i].d, tbl[i].e, tbl[i].h);
    acc(1'h1, 5'h1C, 3'h0, 1'h0, 32'h0, 32'h0, 1'h1);
    acc(1'h1, 5'h1D, 3'h0, 1'h0, 32'h0, 32'h0, 1'h1);
    cop(CDT_OP_STORE_TAG, 1'h0, 6'h05);
    cop(CDT_OP_STORE_TAG, 1'h1, 6'h05);
    acc(1'h1, 5'h1C, 3'h0, 1'h0, 32'hFFFF_FFFF, 32'h0, 1'h1);
    acc(1'h1, 5'h1C, 3'h1, 1'h0, 32'h0, 32'h0, 1'h1);
    acc(1'h1, 5'h1C, 3'h2, 1'h0, 32'h0, 32'h0, 1'h1);
    cop(CDT_OP_NONE, 1'h0, 6'h05);
    cop(CDT_OP_LOAD_TAG, 1'h0, 6'h05);
    cop(CDT_OP_LOAD_TAG, 1'h1, 6'h05);
    acc(1'h0, 5'h1C, 3'h0, 1'h0, 32'h0, 32'h0, 1'h1);
    acc(1'h0, 5'h1C, 3'h1, 1'h0, 32'h0, 32'h1111_1111, 1'h1);
    acc(1'h0, 5'h1D, 3'h1, 1'h0, 32'h0, 32'h3333_3333, 1'h1);
    acc(1'h0, 5'h1C, 3'h2, 1'h0, 32'h0, 32'h1234_5678, 1'h1);
    srst_i = 1'h1;
    repeat (3) @(posedge clk_i);
    #1 srst_i = 1'h0;
    chk(rdata, 32'h0);
    chk({31'h0, done}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
